// ### hdl/ssmt_cfg.svh
// Register offsets, field positions, reset values and timing constants.
// Assumes inclusion by bare name from any design file.
`ifndef SSMT_CFG_SVH
`define SSMT_CFG_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSMT_OFF_CTRL 12'h000
`define SSMT_OFF_CMD 12'h004
`define SSMT_OFF_RATE 12'h008
`define SSMT_OFF_FMT 12'h00c
`define SSMT_OFF_DATA 12'h010
`define SSMT_OFF_STAT 12'h014
// ----------------------------------------
// Control register bits
// ----------------------------------------
`define SSMT_CTRL_FE 0
`define SSMT_CTRL_TXIE 1
`define SSMT_CTRL_RXIE 2
`define SSMT_CTRL_ERIE 3
`define SSMT_CTRL_IDIE 4
`define SSMT_CTRL_MFDE 5
`define SSMT_CTRL_SYNC 6
`define SSMT_CTRL_MASTER_SELECT 7
`define SSMT_CTRL_TXO 8
`define SSMT_CTRL_RST 9'h000
// ----------------------------------------
// Command register fields
// ----------------------------------------
`define SSMT_CMD_CPHA 0
`define SSMT_CMD_CPOL 1
`define SSMT_CMD_BASE_DIVIDER_SELECT_LO 2
`define SSMT_CMD_BASE_DIVIDER_SELECT_HI 3
`define SSMT_CMD_LEN_LO 4
`define SSMT_CMD_LEN_HI 7
`define SSMT_CMD_LSB_FIRST_SELECT 8
`define SSMT_CMD_NADE 9
`define SSMT_CMD_CKDE 10
`define SSMT_CMD_RST 11'h070
`define SSMT_RATE_RST 8'h05
// ----------------------------------------
// Format register fields
// ----------------------------------------
`define SSMT_FMT_PE 0
`define SSMT_FMT_FC_LO 1
`define SSMT_FMT_FC_HI 2
`define SSMT_FMT_AW 3
`define SSMT_FMT_SL_LO 4
`define SSMT_FMT_SL_HI 6
`define SSMT_FMT_RST 7'h00
// ----------------------------------------
// Status bits and timing
// ----------------------------------------
`define SSMT_ST_TXE 0
`define SSMT_ST_IDLE 1
`define SSMT_ST_RXF 2
`define SSMT_NEXT_PCLK 2
`endif

// ### hdl/ssmt_pkg.sv
// Types shared by the serial master transmitter files.
// Assumes ssmt_cfg.svh supplies the numeric constants.
package ssmt_pkg;
  typedef struct packed {
    logic [1:0] base_divider_select;
    logic [7:0] bit_rate_value;
  } ssmt_rate_type;
endpackage

// ### hdl/ssmt_rate_gen.sv
// Bit-rate divider: one-cycle half-period enable pulse.
// Assumes a synchronous clear while no frame is running.
`timescale 1ns/10ps
`include "ssmt_cfg.svh"
module ssmt_rate_gen #(
  parameter int CW = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire ssmt_pkg::ssmt_rate_type rate,
  output logic half_tick
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] lim;
  // ----------------------------------------
  // Half period = (N+1) * 2^base_divider_select pclk
  // ----------------------------------------
  assign lim = CW'(({4'h0, rate.bit_rate_value} + 12'h001) << rate.base_divider_select) - CW'(1);
  assign half_tick = (cnt_q == lim) && !clear;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (clear || half_tick) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule

// ### hdl/ssmt_top.sv
// Three-wire clock-synchronous serial master transmitter with APB registers.
// Assumes a single 250 MHz pclk; the slave needs only clock and data.
// ----------------------------------------
// Summary of operation
// - Master drives serial clock and data out; no slave select exists.
// - Transmit-empty event signals buffer space; software loads words on it.
// - Transmit-only mode: no receive handling, receive-full never set.
// - Code 10b with rate 5 gives total division 48.
// - Base divider field selects division 1, 2, 4 or 8.
// - Length code 0111b with LSB-first clear sends 8 bits MSB first.
// - Phase 1: data changes on odd edges, sampled on even edges.
// - Polarity 1: serial clock rests high outside transfers.
// - Next-access gap is one serial period plus two pclk cycles.
// - Single command, single frame, no sequencing.
// - Parity selectable; enable clear sends no parity bit.
// - Sync mode and master select both set select this operation.
// - Separate interrupt and mode-fault enables, all reset to zero.
// - Flag clears by writing zero only after it was read as one.
// - Flags clear when operation ends, except receive-full.
// ----------------------------------------
`timescale 1ns/10ps
`include "ssmt_cfg.svh"
module ssmt_top #(
  parameter int DW = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic serial_clock_out,
  output logic serial_data_out,
  output logic tx_empty_interrupt,
  output logic idle_interrupt
);
  typedef enum {ssmt_idle, ssmt_delay, ssmt_shift, ssmt_gap} ssmt_state_type;
  ssmt_state_type state_q;
  logic [8:0] ctrl_q;
  logic [10:0] cmd_q;
  logic [7:0] rate_q;
  logic [6:0] fmt_q;
  logic [DW-1:0] buf_q;
  logic buf_full_q;
  logic [DW:0] shreg_q;
  logic [5:0] edge_cnt_q;
  logic [1:0] gap_cnt_q;
  logic sck_q;
  logic sdo_q;
  logic [2:0] seen_q;
  logic [2:0] stat_q;
  logic [31:0] prdata_q;
  logic half_tick;
  logic wr;
  logic rd;
  logic en;
  logic cpol;
  logic cpha;
  logic [5:0] frame_bits;
  logic start;
  logic frame_done;
  logic [DW-1:0] data_in;
  ssmt_pkg::ssmt_rate_type rate;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign prdata = prdata_q;
  // Active only in this mode; other settings leave the link still.
  assign en = ctrl_q[`SSMT_CTRL_FE] && ctrl_q[`SSMT_CTRL_SYNC] && ctrl_q[`SSMT_CTRL_MASTER_SELECT];
  assign cpol = cmd_q[`SSMT_CMD_CPOL];
  assign cpha = cmd_q[`SSMT_CMD_CPHA];
  assign rate.base_divider_select = cmd_q[`SSMT_CMD_BASE_DIVIDER_SELECT_HI:`SSMT_CMD_BASE_DIVIDER_SELECT_LO];
  assign rate.bit_rate_value = rate_q;
  // Bits = length code + 1, plus parity; two edges per bit.
  assign frame_bits = 6'({2'b00, cmd_q[`SSMT_CMD_LEN_HI:`SSMT_CMD_LEN_LO]}) + 6'h01
                      + 6'(fmt_q[`SSMT_FMT_PE]);
  // Frame length is limited by the data width parameter.
  assign data_in = pwdata[DW-1:0];

  // Sixteen bit mask, then reorder for LSB-first
  function automatic logic [DW:0] load_word(input logic [DW-1:0] d, input logic [3:0] lc,
                                             input logic lsb_first_select, input logic pe);
    logic [DW-1:0] m;
    logic [DW-1:0] r;
    logic par;
    int n;
    m = '0;
    r = '0;
    par = 1'b0;
    n = int'(lc) + 1;
    for (int i = 0; i < DW; i++) begin
      if (i < n) begin
        m[i] = d[i];
        par = par ^ d[i];
      end
    end
    // Left-justify so the MSB leaves first, or the LSB when LSB-first is set
    for (int i = 0; i < DW; i++) begin
      if (i < n) begin
        r[DW-1-i] = lsb_first_select ? m[i] : m[n-1-i];
      end
    end
    load_word = {r, 1'b0};
    if (pe) begin
      load_word[DW-n] = ~par;
    end
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `SSMT_CTRL_RST;
      cmd_q <= `SSMT_CMD_RST;
      rate_q <= `SSMT_RATE_RST;
      fmt_q <= `SSMT_FMT_RST;
    end else if (wr) begin
      if (hit(paddr, `SSMT_OFF_CTRL)) begin
        ctrl_q <= pwdata[8:0];
      end
      if (hit(paddr, `SSMT_OFF_CMD)) begin
        cmd_q <= pwdata[10:0];
      end
      if (hit(paddr, `SSMT_OFF_RATE)) begin
        rate_q <= pwdata[7:0];
      end
      if (hit(paddr, `SSMT_OFF_FMT)) begin
        fmt_q <= pwdata[6:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SSMT_OFF_CTRL: prdata_q <= {23'h0, ctrl_q};
        `SSMT_OFF_CMD: prdata_q <= {21'h0, cmd_q};
        `SSMT_OFF_RATE: prdata_q <= {24'h0, rate_q};
        `SSMT_OFF_FMT: prdata_q <= {25'h0, fmt_q};
        `SSMT_OFF_STAT: prdata_q <= {29'h0, stat_q};
        default: prdata_q <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  assign start = (state_q == ssmt_idle) && buf_full_q && en;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q <= '0;
      buf_full_q <= 1'b0;
    end else if (!en) begin
      buf_full_q <= 1'b0;
    end else if (wr && hit(paddr, `SSMT_OFF_DATA) && !buf_full_q) begin
      buf_q <= data_in;
      buf_full_q <= 1'b1;
    end else if (start) begin
      buf_full_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Shift engine
  // ----------------------------------------
  ssmt_rate_gen #(
    .CW(12)
  ) u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .clear(state_q == ssmt_idle),
    .rate(rate),
    .half_tick(half_tick)
  );

  assign frame_done = (state_q == ssmt_shift) && half_tick && (edge_cnt_q == 6'((frame_bits << 1) - 6'h01));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ssmt_idle;
      edge_cnt_q <= '0;
      gap_cnt_q <= '0;
    end else if (!en) begin
      state_q <= ssmt_idle;
    end else begin
      case (state_q)
        ssmt_idle: begin
          if (start) begin
            state_q <= ssmt_delay;
            edge_cnt_q <= '0;
          end
        end
        ssmt_delay: begin
          // Half a period here, the other half before the first shift edge
          if (half_tick) begin
            state_q <= ssmt_shift;
            edge_cnt_q <= '0;
          end
        end
        ssmt_shift: begin
          if (half_tick) begin
            edge_cnt_q <= edge_cnt_q + 6'h01;
          end
          if (frame_done) begin
            state_q <= ssmt_gap;
            edge_cnt_q <= '0;
            gap_cnt_q <= '0;
          end
        end
        ssmt_gap: begin
          // One serial period, then two pclk
          if (edge_cnt_q < 6'h02) begin
            if (half_tick) begin
              edge_cnt_q <= edge_cnt_q + 6'h01;
            end
          end else if (gap_cnt_q == 2'(`SSMT_NEXT_PCLK - 1)) begin
            state_q <= ssmt_idle;
          end else begin
            gap_cnt_q <= gap_cnt_q + 2'h1;
          end
        end
        default: state_q <= ssmt_idle;
      endcase
    end
  end

  // Clock toggles on each half tick while shifting; rests at polarity.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b1;
    end else if (state_q == ssmt_shift && half_tick) begin
      sck_q <= ~sck_q;
    end else if (state_q != ssmt_shift) begin
      sck_q <= cpol;
    end
  end

  // Phase 1 drives each bit at odd edges; phase 0 presents bit 0 early.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg_q <= '0;
      sdo_q <= 1'b1;
    end else if (start) begin
      shreg_q <= load_word(buf_q, cmd_q[`SSMT_CMD_LEN_HI:`SSMT_CMD_LEN_LO], cmd_q[`SSMT_CMD_LSB_FIRST_SELECT],
                           fmt_q[`SSMT_FMT_PE]);
    end else if (state_q == ssmt_delay && half_tick && !cpha) begin
      sdo_q <= shreg_q[DW];
      shreg_q <= {shreg_q[DW-1:0], 1'b0};
    end else if (state_q == ssmt_shift && half_tick && (edge_cnt_q[0] == 1'b0) == cpha) begin
      if (!(cpha == 1'b0 && edge_cnt_q == 6'((frame_bits << 1) - 6'h01))) begin
        sdo_q <= shreg_q[DW];
        shreg_q <= {shreg_q[DW-1:0], 1'b0};
      end
    end
  end

  assign serial_clock_out = sck_q;
  assign serial_data_out = sdo_q;

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_q <= '0;
      stat_q <= '0;
    end else begin
      if (rd && hit(paddr, `SSMT_OFF_STAT)) begin
        seen_q <= stat_q;
      end
      for (int i = 0; i < 3; i++) begin
        if (wr && hit(paddr, `SSMT_OFF_STAT) && !pwdata[i] && seen_q[i]) begin
          stat_q[i] <= 1'b0;
          seen_q[i] <= 1'b0;
        end
      end
      if (!en) begin
        stat_q[`SSMT_ST_TXE] <= 1'b0;
        stat_q[`SSMT_ST_IDLE] <= 1'b0;
        seen_q[1:0] <= 2'b00;
      end else begin
        if (!buf_full_q) begin
          stat_q[`SSMT_ST_TXE] <= 1'b1;
        end
        if (state_q == ssmt_idle && !buf_full_q) begin
          stat_q[`SSMT_ST_IDLE] <= 1'b1;
        end
      end
      // Transmit-only: receive-full is never set here
      if (ctrl_q[`SSMT_CTRL_TXO]) begin
        stat_q[`SSMT_ST_RXF] <= stat_q[`SSMT_ST_RXF] && !(wr && hit(paddr, `SSMT_OFF_STAT) && seen_q[2]
                                && !pwdata[2]);
      end
    end
  end

  assign tx_empty_interrupt = en && !buf_full_q && ctrl_q[`SSMT_CTRL_TXIE];
  assign idle_interrupt = en && state_q == ssmt_idle && !buf_full_q && ctrl_q[`SSMT_CTRL_IDIE];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_idle_level;
    @(posedge pclk) disable iff (!presetn) (state_q == ssmt_idle) |=> (sck_q == $past(cpol) || state_q != ssmt_idle);
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("Serial clock not at rest level");
  property p_delay_first;
    @(posedge pclk) disable iff (!presetn) start |=> (state_q == ssmt_delay) && $stable(sck_q);
  endproperty
  a_delay_first: assert property (p_delay_first) else $error("No delay before first edge");
  property p_no_clock_off;
    @(posedge pclk) disable iff (!presetn) !en |=> ##1 (sck_q == cpol || !$stable(cpol));
  endproperty
  a_no_clock_off: assert property (p_no_clock_off) else $error("Clock moved while disabled");
  property p_gap_end;
    @(posedge pclk) disable iff (!presetn) (state_q == ssmt_gap && edge_cnt_q == 6'h02 && gap_cnt_q == 2'h0 && en)
      |=> ##1 (state_q == ssmt_idle || !en);
  endproperty
  a_gap_end: assert property (p_gap_end) else $error("Gap length wrong");
  property p_load;
    @(posedge pclk) disable iff (!presetn) (wr && hit(paddr, `SSMT_OFF_DATA) && en && !buf_full_q) |=> buf_full_q;
  endproperty
  a_load: assert property (p_load) else $error("Data write not taken");
  property p_txe_irq;
    @(posedge pclk) disable iff (!presetn) (buf_full_q) |-> !tx_empty_interrupt;
  endproperty
  a_txe_irq: assert property (p_txe_irq) else $error("Empty interrupt while full");
  property p_flag_end;
    @(posedge pclk) disable iff (!presetn) $fell(en) |=> (stat_q[1:0] == 2'b00);
  endproperty
  a_flag_end: assert property (p_flag_end) else $error("Flags not cleared at end");
  property p_clear_needs_read;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit(paddr, `SSMT_OFF_STAT) && !seen_q[`SSMT_ST_TXE] && en && buf_full_q)
      |=> $stable(stat_q[`SSMT_ST_TXE]);
  endproperty
  a_clear_needs_read: assert property (p_clear_needs_read) else $error("Flag cleared without read");
  property p_edges;
    @(posedge pclk) disable iff (!presetn) frame_done |=> (state_q == ssmt_gap);
  endproperty
  a_edges: assert property (p_edges) else $error("Frame end not followed by gap");
  c_start: cover property (@(posedge pclk) disable iff (!presetn) start);
  c_frame: cover property (@(posedge pclk) disable iff (!presetn) frame_done);
  c_idle_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(idle_interrupt));
endmodule

// ### verif/ssmt_slave_model.sv
// Receiving slave beside the serial master transmitter: captures bytes off the wire.
// Assumes idle-high clock, data changed on falling and sampled on rising edges.
`timescale 1ns/10ps
module ssmt_slave_model (
  input wire logic sck,
  input wire logic sdo,
  input wire logic clear,
  output int n_bytes,
  output int setup_err
);
  // ----------------------------------------
  // Capture
  // ----------------------------------------
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  int nbit;
  realtime t_chg;
  always @(sdo) t_chg = $realtime;
  // Clear drops edges seen while the polarity is being set up
  always @(posedge sck or posedge clear) begin
    if (clear) begin
      nbit = 0;
      n_bytes = 0;
      setup_err = 0;
    end else begin
      if ($realtime - t_chg < 20.0) setup_err++;
      sh = {sh[6:0], sdo};
      nbit++;
      if (nbit == 8) begin
        mem[n_bytes[7:0]] = sh;
        n_bytes++;
        nbit = 0;
      end
    end
  end
endmodule

// ### verif/ssmt_tb_top.sv
// Self-checking bench for the serial master transmitter over APB.
// Assumes the slave model file is compiled first.
`timescale 1ns/10ps
`include "ssmt_cfg.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin n_errors++; $display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp); end end
module ssmt_tb_top;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, clr = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, serial_clock_out, serial_data_out, tx_empty_interrupt, idle_interrupt, sck_prev;
  int n_errors = 0, cmp_count = 0, n_bytes, setup_err;
  int cyc = 0, last_cyc = 0, first_cyc = 0, w_cyc = 0, n_edges = 0, hmin = 999, hmax = 0, gmin = 999, iv, e0;
  bit meas_on = 0;
  always #2 pclk = ~pclk;
  ssmt_top ssmt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clock_out(serial_clock_out), .serial_data_out(serial_data_out),
    .tx_empty_interrupt(tx_empty_interrupt), .idle_interrupt(idle_interrupt));
  ssmt_slave_model ssmt_slave_model_inst (.sck(serial_clock_out), .sdo(serial_data_out), .clear(clr),
    .n_bytes(n_bytes), .setup_err(setup_err));
  // ----------------------------------------
  // Serial clock edge timing, sampled away from the pclk edge
  // ----------------------------------------
  always @(negedge pclk) begin
    cyc++;
    if (serial_clock_out !== sck_prev) begin
      n_edges++;
      iv = cyc - last_cyc;
      if (meas_on) begin
        if (first_cyc == 0) first_cyc = cyc;
        else if (iv <= 40) begin
          if (iv < hmin) hmin = iv;
          if (iv > hmax) hmax = iv;
        end else if (iv < gmin) gmin = iv;
      end
      last_cyc = cyc;
    end
    sck_prev = serial_clock_out;
  end
  // ----------------------------------------
  // APB master
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask
  // Bounded wait on one of the two events
  task automatic wait_irq(input bit idle);
    int k;
    k = 0;
    repeat (2) @(posedge pclk);
    while (((idle ? idle_interrupt : tx_empty_interrupt) !== 1'b1) && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (k >= 3000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: event wait timed out", $time);
    end
  endtask
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Watchdog: 128 frames of about 500 cycles plus setup
  // ----------------------------------------
  initial begin
    repeat (95000) @(posedge pclk);
    n_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    test_done();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(serial_clock_out, 1'b1)
    rdchk(`SSMT_OFF_CTRL, 32'h0);
    rdchk(`SSMT_OFF_CMD, 32'h70);
    rdchk(`SSMT_OFF_RATE, 32'h5);
    rdchk(`SSMT_OFF_FMT, 32'h0);
    apb(1'b1, 12'h020, 32'hffff);
    rdchk(12'h020, 32'h0);
    `CHK(pslverr, 1'b0)
    // Clock, format and mode set with the function still off
    apb(1'b1, `SSMT_OFF_CMD, 32'h7b);
    apb(1'b1, `SSMT_OFF_RATE, 32'h5);
    apb(1'b1, `SSMT_OFF_FMT, 32'h0);
    apb(1'b1, `SSMT_OFF_CTRL, 32'h1c0);
    rdchk(`SSMT_OFF_CTRL, 32'h1c0);
    `CHK(tx_empty_interrupt, 1'b0)
    // Data while disabled, then with sync mode missing: no clock
    e0 = n_edges;
    apb(1'b1, `SSMT_OFF_DATA, 32'ha5);
    repeat (300) @(posedge pclk);
    `CHK(n_edges, e0)
    apb(1'b1, `SSMT_OFF_CTRL, 32'h181);
    apb(1'b1, `SSMT_OFF_DATA, 32'h5a);
    repeat (300) @(posedge pclk);
    `CHK(n_edges, e0)
    // Flush anything held before the measured run
    apb(1'b1, `SSMT_OFF_CTRL, 32'h1c3);
    repeat (700) @(posedge pclk);
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    meas_on = 1;
    for (int i = 1; i <= 128; i++) begin
      wait_irq(1'b0);
      apb(1'b1, `SSMT_OFF_DATA, 32'(i));
      if (i == 1) w_cyc = cyc;
      if (i == 2) begin
        // Buffer full and engine busy: hardware cannot set flags here
        apb(1'b1, `SSMT_OFF_STAT, 32'h0);
        rdchk(`SSMT_OFF_STAT, 32'h3);
        apb(1'b1, `SSMT_OFF_STAT, 32'h0);
        rdchk(`SSMT_OFF_STAT, 32'h0);
      end
    end
    apb(1'b1, `SSMT_OFF_CTRL, 32'h1d1);
    wait_irq(1'b1);
    `CHK(tx_empty_interrupt, 1'b0)
    `CHK(n_bytes, 128)
    for (int i = 0; i < 128; i++) `CHK(ssmt_slave_model_inst.mem[i], 8'(i + 1))
    `CHK(setup_err, 0)
    `CHK(hmin, 24)
    `CHK(hmax, 24)
    `CHK((first_cyc - w_cyc >= 48) && (first_cyc - w_cyc <= 56), 1'b1)
    // Gap plus the clock delay of the next frame: 48 + 2 + 48 pclk
    `CHK((gmin >= 98) && (gmin <= 102), 1'b1)
    `CHK(serial_clock_out, 1'b1)
    apb(1'b1, `SSMT_OFF_CTRL, 32'h1c0);
    rdchk(`SSMT_OFF_STAT, 32'h0);
    // Seven bits LSB first plus odd parity fill one byte on the wire
    apb(1'b1, `SSMT_OFF_CMD, 32'h16b);
    apb(1'b1, `SSMT_OFF_FMT, 32'h1);
    apb(1'b1, `SSMT_OFF_CTRL, 32'h1d1);
    apb(1'b1, `SSMT_OFF_DATA, 32'h15);
    wait_irq(1'b1);
    `CHK(n_bytes, 129)
    `CHK(ssmt_slave_model_inst.mem[128], 8'ha8)
    `CHK(setup_err, 0)
    apb(1'b1, `SSMT_OFF_CTRL, 32'h1c0);
    rdchk(`SSMT_OFF_STAT, 32'h0);
    test_done();
  end
endmodule
